/* design/status_pin_pkg.sv */
package status_pin_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_GLOBAL_CONFIG  = 7'h00;
	localparam logic [6:0] IDX_PIN_VALUE      = 7'h02;
	localparam logic [6:0] IDX_TX_SECTION_CFG = 7'h0C;
	localparam logic [6:0] IDX_TX_LINE_CFG    = 7'h0D;
	localparam logic [6:0] IDX_PIN_VALUE_ALT  = 7'h41;
	localparam logic [6:0] IDX_RX_LINE_CFG    = 7'h46;
	localparam logic [6:0] IDX_PIN_STATE      = 7'h50;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int GCFG_ALARM_SEL_BIT = 2;
	localparam int RX_LINE_CONFIG_DL_SEL0_BIT  = 0;
	localparam int RX_LINE_CONFIG_DL_SEL1_BIT  = 1;
	localparam int TX_LINE_CONFIG_DL_SEL_BIT   = 4;
	localparam int TX_SECTION_CONFIG_DL_SEL_BIT   = 6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_GLOBAL_CONFIG = 8'h00;
	localparam logic [7:0] RST_PIN_VALUE     = 8'h00;
	localparam logic [7:0] RST_TX_SECTION    = 8'h00;
	localparam logic [7:0] RST_TX_LINE       = 8'h00;
	localparam logic [7:0] RST_RX_LINE       = 8'h00;

	// ------------------------------------------------------------
	// test access port states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET      = 4'h0,
		TAP_IDLE       = 4'h1,
		TAP_DR_SELECT  = 4'h2,
		TAP_DR_CAPTURE = 4'h3,
		TAP_DR_SHIFT   = 4'h4,
		TAP_DR_EXIT1   = 4'h5,
		TAP_DR_PAUSE   = 4'h6,
		TAP_DR_EXIT2   = 4'h7,
		TAP_DR_UPDATE  = 4'h8,
		TAP_IR_SELECT  = 4'h9,
		TAP_IR_CAPTURE = 4'hA,
		TAP_IR_SHIFT   = 4'hB,
		TAP_IR_EXIT1   = 4'hC,
		TAP_IR_PAUSE   = 4'hD,
		TAP_IR_EXIT2   = 4'hE,
		TAP_IR_UPDATE  = 4'hF
	} tap_state_t;

endpackage

/* design/status_output_pin_mux.sv */
`timescale 1ns/1ps
//
// Contract
// - pin 7 is value bit 7 or signal_absent
// - wan: pin 7 carries receive link clock
// - pin 6 is value bit 6 or frame_lost
// - wan: pin 6 carries receive link data
// - pin 5 is value bit 5 or pointer_invalid
// - wan: pin 5 high for first-group receive octets
// - pin 4 is value bit 4 or line_alarm_forward
// - wan: pin 4 carries transmit link clock
// - pin 3 is value bit 3 or line_far_defect
// - wan: pin 3 high for first-group transmit bits
// - pin 2 is value bit 2 or path_alarm_forward
// - wan: pin 2 pulses each cell slot start
// - pin 1 is value bit 1 or path_far_defect
// - pin 0 is value bit 0 or cell_delineation_lost
// - low test reset clears boundary-scan logic
// - mode and data sampled on test clock rise
//
module status_output_pin_mux
	import status_pin_pkg::*;
#(
	parameter bit WAN_VARIANT = 1'b1
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [8:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// live alarms from the core, same clock
	input  wire logic        signal_absent,
	input  wire logic        frame_lost,
	input  wire logic        pointer_invalid,
	input  wire logic        line_alarm_forward,
	input  wire logic        line_far_defect,
	input  wire logic        path_alarm_forward,
	input  wire logic        path_far_defect,
	input  wire logic        cell_delineation_lost,
	// overhead data link timing from the core, same clock
	input  wire logic        rx_link_clk,
	input  wire logic        rx_link_data,
	input  wire logic        rx_link_first_group,
	input  wire logic        tx_link_clk,
	input  wire logic        tx_link_first_group,
	// toggles once per cell slot, utopia transmit domain
	input  wire logic        cell_slot_toggle,
	// boundary-scan pins, asynchronous to clk
	input  wire logic        test_reset_n,
	input  wire logic        test_clk,
	input  wire logic        test_mode_sel,
	input  wire logic        test_data_in,
	output logic             test_data_out,
	// board-facing status pins
	output logic [7:0]       status_pins
);

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [7:0] global_config_reg;  // bit 2 picks live alarms
	logic [7:0] pin_value_reg;      // software-driven pin levels
	logic [7:0] tx_section_config_reg;
	logic [7:0] tx_line_config_reg;
	logic [7:0] rx_line_config_reg;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic       access_done;  // edge at which the transfer completes
	logic [6:0] reg_index;
	logic       addr_ok;

	// true for every index that has a register behind it
	function automatic logic index_mapped(input logic [6:0] idx);
		case (idx)
			IDX_GLOBAL_CONFIG, IDX_PIN_VALUE, IDX_TX_SECTION_CFG,
			IDX_TX_LINE_CFG, IDX_PIN_VALUE_ALT, IDX_RX_LINE_CFG,
			IDX_PIN_STATE: index_mapped = 1'b1;
			default:       index_mapped = 1'b0;
		endcase
	endfunction

	assign reg_index   = paddr[8:2];
	// byte lanes other than word-aligned addresses are not decoded
	assign addr_ok     = index_mapped(reg_index) && (paddr[1:0] == 2'b00);
	assign access_done = psel && penable && pready;

	// one wait state keeps pready a plain flop output
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;
	end

	// read data and error flag are set up together with pready
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && penable && !pready)
		begin
			pslverr <= !addr_ok;
			prdata  <= 32'h0000_0000;
			if (!pwrite)
			begin
				case (reg_index)
					IDX_GLOBAL_CONFIG:
						prdata <= {24'h00_0000, global_config_reg};
					IDX_PIN_VALUE, IDX_PIN_VALUE_ALT:
						prdata <= {24'h00_0000, pin_value_reg};
					IDX_TX_SECTION_CFG:
						prdata <= {24'h00_0000, tx_section_config_reg};
					IDX_TX_LINE_CFG:
						prdata <= {24'h00_0000, tx_line_config_reg};
					IDX_RX_LINE_CFG:
						prdata <= {24'h00_0000, rx_line_config_reg};
					IDX_PIN_STATE:
						prdata <= {24'h00_0000, status_pins};
					default:
						prdata <= 32'h0000_0000;
				endcase
			end
		end
		else
		begin
			pslverr <= 1'b0;
		end
	end

	// writes land only at the completing edge; both value offsets
	// alias one register so either view drives all eight pins
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			global_config_reg     <= RST_GLOBAL_CONFIG;
			pin_value_reg         <= RST_PIN_VALUE;
			tx_section_config_reg <= RST_TX_SECTION;
			tx_line_config_reg    <= RST_TX_LINE;
			rx_line_config_reg    <= RST_RX_LINE;
		end
		else if (access_done && pwrite && addr_ok)
		begin
			case (reg_index)
				IDX_GLOBAL_CONFIG:  global_config_reg     <= pwdata[7:0];
				IDX_PIN_VALUE:      pin_value_reg         <= pwdata[7:0];
				IDX_PIN_VALUE_ALT:  pin_value_reg         <= pwdata[7:0];
				IDX_TX_SECTION_CFG: tx_section_config_reg <= pwdata[7:0];
				IDX_TX_LINE_CFG:    tx_line_config_reg    <= pwdata[7:0];
				IDX_RX_LINE_CFG:    rx_line_config_reg    <= pwdata[7:0];
				default:            ;  // pin state view is read only
			endcase
		end
	end

	// ------------------------------------------------------------
	// cell slot event crossing
	// ------------------------------------------------------------
	logic [2:0] slot_sync;       // [0] is only read by [1]
	logic       slot_level_reg;  // toggle level last counted
	logic       slot_settled;    // stages two and three agree
	logic       slot_pulse;      // one clk per cell slot start

	// toggle crossing: one clk pulse per slot, while each toggle level lasts over two clk edges
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			slot_sync <= 3'b000;
		else
			slot_sync <= {slot_sync[1:0], cell_slot_toggle};
	end

	// a change counts only once the last two stages agree, so a
	// toggle caught mid-flight in stage one never fires twice
	assign slot_settled = slot_sync[2] == slot_sync[1];

	// settled level remembers which toggle level was last counted
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			slot_level_reg <= 1'b0;
		else if (slot_settled)
			slot_level_reg <= slot_sync[2];
	end

	// one pulse per settled change; costs one cycle of latency
	assign slot_pulse = slot_settled &&
		(slot_sync[2] != slot_level_reg);

	// ------------------------------------------------------------
	// pin source selection
	// ------------------------------------------------------------
	logic       rx_link_sel;
	logic       tx_link_sel;
	logic [7:0] alarms;
	logic [7:0] pins_next;

	// receive link owns pins 7..5, transmit link owns pins 4..2
	assign rx_link_sel = WAN_VARIANT &&
		(rx_line_config_reg[RX_LINE_CONFIG_DL_SEL0_BIT] ||
		 rx_line_config_reg[RX_LINE_CONFIG_DL_SEL1_BIT]);
	assign tx_link_sel = WAN_VARIANT &&
		(tx_line_config_reg[TX_LINE_CONFIG_DL_SEL_BIT] ||
		 tx_section_config_reg[TX_SECTION_CONFIG_DL_SEL_BIT]);

	assign alarms = {signal_absent, frame_lost, pointer_invalid,
		line_alarm_forward, line_far_defect, path_alarm_forward,
		path_far_defect, cell_delineation_lost};

	// link functions win over the alarm / register choice
	always_comb
	begin
		pins_next = global_config_reg[GCFG_ALARM_SEL_BIT] ?
			alarms : pin_value_reg;
		if (rx_link_sel)
		begin
			pins_next[7] = rx_link_clk;
			pins_next[6] = rx_link_data;
			pins_next[5] = rx_link_first_group;
		end
		if (tx_link_sel)
		begin
			pins_next[4] = tx_link_clk;
			// board must shift first-group bits while this is high
			pins_next[3] = tx_link_first_group;
			pins_next[2] = slot_pulse;
		end
	end

	// pins are flopped, so each source shows one clk later
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			status_pins <= 8'h00;
		else
			status_pins <= pins_next;
	end

	// ------------------------------------------------------------
	// boundary-scan port (bypass only)
	// ------------------------------------------------------------
	logic [2:0] trst_sync;  // test reset, low active
	logic [2:0] tck_sync;
	logic [2:0] tms_sync;
	logic [2:0] tdi_sync;
	logic       tck_level_reg;  // settled test clock level
	logic       tck_settled;    // stages two and three agree
	logic       tck_rise;       // one clk per test clock rise
	logic       tap_reset;
	tap_state_t tap_state_reg;
	tap_state_t tap_state_next;
	logic       bypass_reg;

	// three stages; test reset asserts and test clock counts a change once stages two and three agree, mode and data are read at stage three
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			trst_sync <= 3'b111;
			tck_sync  <= 3'b000;
			tms_sync  <= 3'b111;
			tdi_sync  <= 3'b111;
		end
		else
		begin
			trst_sync <= {trst_sync[1:0], test_reset_n};
			tck_sync  <= {tck_sync[1:0], test_clk};
			tms_sync  <= {tms_sync[1:0], test_mode_sel};
			tdi_sync  <= {tdi_sync[1:0], test_data_in};
		end
	end

	// the pad pull-up makes an open pin read high, i.e. inactive
	assign tap_reset = !trst_sync[2] && !trst_sync[1];
	assign tck_settled = tck_sync[2] == tck_sync[1];
	// a rise counts once stages two and three agree on high
	assign tck_rise  = tck_settled && tck_sync[2] && !tck_level_reg;

	// reset low, the idle level of the test clock, so that no
	// false rise follows reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tck_level_reg <= 1'b0;
		else if (tck_settled)
			tck_level_reg <= tck_sync[2];
	end

	// standard tap walk driven by the mode-select level
	always_comb
	begin
		tap_state_next = TAP_RESET;
		case (tap_state_reg)
			TAP_RESET:      tap_state_next = tms_sync[2] ? TAP_RESET
				: TAP_IDLE;
			TAP_IDLE:       tap_state_next = tms_sync[2] ? TAP_DR_SELECT
				: TAP_IDLE;
			TAP_DR_SELECT:  tap_state_next = tms_sync[2] ? TAP_IR_SELECT
				: TAP_DR_CAPTURE;
			TAP_DR_CAPTURE: tap_state_next = tms_sync[2] ? TAP_DR_EXIT1
				: TAP_DR_SHIFT;
			TAP_DR_SHIFT:   tap_state_next = tms_sync[2] ? TAP_DR_EXIT1
				: TAP_DR_SHIFT;
			TAP_DR_EXIT1:   tap_state_next = tms_sync[2] ? TAP_DR_UPDATE
				: TAP_DR_PAUSE;
			TAP_DR_PAUSE:   tap_state_next = tms_sync[2] ? TAP_DR_EXIT2
				: TAP_DR_PAUSE;
			TAP_DR_EXIT2:   tap_state_next = tms_sync[2] ? TAP_DR_UPDATE
				: TAP_DR_SHIFT;
			TAP_DR_UPDATE:  tap_state_next = tms_sync[2] ? TAP_DR_SELECT
				: TAP_IDLE;
			TAP_IR_SELECT:  tap_state_next = tms_sync[2] ? TAP_RESET
				: TAP_IR_CAPTURE;
			TAP_IR_CAPTURE: tap_state_next = tms_sync[2] ? TAP_IR_EXIT1
				: TAP_IR_SHIFT;
			TAP_IR_SHIFT:   tap_state_next = tms_sync[2] ? TAP_IR_EXIT1
				: TAP_IR_SHIFT;
			TAP_IR_EXIT1:   tap_state_next = tms_sync[2] ? TAP_IR_UPDATE
				: TAP_IR_PAUSE;
			TAP_IR_PAUSE:   tap_state_next = tms_sync[2] ? TAP_IR_EXIT2
				: TAP_IR_PAUSE;
			TAP_IR_EXIT2:   tap_state_next = tms_sync[2] ? TAP_IR_UPDATE
				: TAP_IR_SHIFT;
			TAP_IR_UPDATE:  tap_state_next = tms_sync[2] ? TAP_DR_SELECT
				: TAP_IDLE;
			default:        tap_state_next = TAP_RESET;
		endcase
	end

	// state moves only on a detected test clock rise or a reset
	always_ff @(posedge clk)
	begin
		if (!rst_n || tap_reset)
			tap_state_reg <= TAP_RESET;
		else if (tck_rise)
			tap_state_reg <= tap_state_next;
	end

	// one-bit bypass path; instruction shift also uses it
	always_ff @(posedge clk)
	begin
		if (!rst_n || tap_reset)
			bypass_reg <= 1'b0;
		else if (tck_rise && (tap_state_reg == TAP_DR_SHIFT ||
			tap_state_reg == TAP_IR_SHIFT))
			bypass_reg <= tdi_sync[2];
		else if (tck_rise && tap_state_reg == TAP_DR_CAPTURE)
			bypass_reg <= 1'b0;
	end

	// output follows the bypass bit, held low outside shifting
	always_ff @(posedge clk)
	begin
		if (!rst_n || tap_reset)
			test_data_out <= 1'b0;
		else if (tap_state_reg == TAP_DR_SHIFT ||
			tap_state_reg == TAP_IR_SHIFT)
			test_data_out <= bypass_reg;
		else
			test_data_out <= 1'b0;
	end

endmodule

/* verification/status_pin_chk.sv */
`timescale 1ns/1ps
module status_pin_chk
	import status_pin_pkg::*;
#(
	parameter bit WAN_VARIANT = 1'b1
)
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [8:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        signal_absent,
	input wire logic        frame_lost,
	input wire logic        pointer_invalid,
	input wire logic        line_alarm_forward,
	input wire logic        line_far_defect,
	input wire logic        path_alarm_forward,
	input wire logic        path_far_defect,
	input wire logic        cell_delineation_lost,
	input wire logic        rx_link_clk,
	input wire logic        rx_link_data,
	input wire logic        rx_link_first_group,
	input wire logic        tx_link_clk,
	input wire logic        tx_link_first_group,
	input wire logic        cell_slot_toggle,
	input wire logic [7:0]  status_pins
);
	// ------------------------------------------------------------
	// shadow of the control registers, fed by completed writes
	// ------------------------------------------------------------
	logic [7:0] gcfg_reg, pval_reg, txs_reg, txl_reg, rxl_reg, alarms;
	logic       wr_ok, rx_sel, tx_sel, plain;
	assign wr_ok  = psel && penable && pready && pwrite && !pslverr;
	assign rx_sel = WAN_VARIANT && (rxl_reg[0] || rxl_reg[1]);
	assign tx_sel = WAN_VARIANT && (txl_reg[4] || txs_reg[6]);
	assign plain  = !rx_sel && !tx_sel;
	assign alarms = {signal_absent, frame_lost, pointer_invalid,
		line_alarm_forward, line_far_defect, path_alarm_forward,
		path_far_defect, cell_delineation_lost};
	// refused writes carry pslverr, so they never reach the shadow
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			{gcfg_reg, pval_reg, txs_reg, txl_reg, rxl_reg} <= 40'h0;
		else if (wr_ok)
			case (paddr[8:2])
				IDX_GLOBAL_CONFIG:  gcfg_reg <= pwdata[7:0];
				IDX_PIN_VALUE:      pval_reg <= pwdata[7:0];
				IDX_PIN_VALUE_ALT:  pval_reg <= pwdata[7:0];
				IDX_TX_SECTION_CFG: txs_reg <= pwdata[7:0];
				IDX_TX_LINE_CFG:    txl_reg <= pwdata[7:0];
				IDX_RX_LINE_CFG:    rxl_reg <= pwdata[7:0];
				default: ;
			endcase
	end
	// ------------------------------------------------------------
	// pin and bus relations, pins lag their source by one edge, pin 2 its toggle by 2 to 5
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_slot_start;
		$changed(cell_slot_toggle) ##0 tx_sel;
	endsequence
	sequence s_slot_pulse;
		##[2:5] status_pins[2];
	endsequence
	a_value_high: assert property (
		plain && !gcfg_reg[GCFG_ALARM_SEL_BIT]
		|=> status_pins[7:4] == $past(pval_reg[7:4]))
		else $error("upper pins differ from value register");
	a_value_low: assert property (
		plain && !gcfg_reg[GCFG_ALARM_SEL_BIT]
		|=> status_pins[3:0] == $past(pval_reg[3:0]))
		else $error("lower pins differ from value register");
	a_alarm_pins: assert property (
		plain && gcfg_reg[GCFG_ALARM_SEL_BIT]
		|=> status_pins == $past(alarms))
		else $error("pins differ from live alarms");
	a_rx_link: assert property (
		rx_sel |=> status_pins[7:5] == $past({rx_link_clk,
		rx_link_data, rx_link_first_group}))
		else $error("receive link pins wrong");
	a_tx_link: assert property (
		tx_sel |=> status_pins[4:3] ==
		$past({tx_link_clk, tx_link_first_group}))
		else $error("transmit link pins wrong");
	a_slot_pulse: assert property (
		s_slot_start |-> s_slot_pulse)
		else $error("no pulse after cell slot start");
	a_pulse_single: assert property (
		tx_sel && $past(tx_sel) && status_pins[2] |=> !status_pins[2])
		else $error("cell slot pulse longer than one cycle");
	a_apb_wait: assert property (
		psel && $rose(penable) |=> pready)
		else $error("pready not on second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_misalign_err: assert property (
		psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access without error");
endmodule

bind status_output_pin_mux status_pin_chk
	#(.WAN_VARIANT(WAN_VARIANT)) u_chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr),
	.signal_absent(signal_absent), .frame_lost(frame_lost),
	.pointer_invalid(pointer_invalid),
	.line_alarm_forward(line_alarm_forward),
	.line_far_defect(line_far_defect),
	.path_alarm_forward(path_alarm_forward),
	.path_far_defect(path_far_defect),
	.cell_delineation_lost(cell_delineation_lost),
	.rx_link_clk(rx_link_clk), .rx_link_data(rx_link_data),
	.rx_link_first_group(rx_link_first_group),
	.tx_link_clk(tx_link_clk),
	.tx_link_first_group(tx_link_first_group),
	.cell_slot_toggle(cell_slot_toggle),
	.status_pins(status_pins));

/* verification/board_monitor.sv */
`timescale 1ns/1ps
// board logic watching the pins: counts cell slot pulses on pin 2
module board_monitor
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] status_pins,
	output logic [7:0]      slot_count
);
	logic pin2_reg;  // last level seen on pin 2
	// a rising level is one slot; a stuck-high pin counts only once
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin2_reg   <= 1'b0;
			slot_count <= 8'h00;
		end
		else
		begin
			pin2_reg <= status_pins[2];
			if (status_pins[2] && !pin2_reg)
				slot_count <= slot_count + 8'h01;
		end
	end
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
	import status_pin_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [8:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        signal_absent, frame_lost, pointer_invalid;
	logic        line_alarm_forward, line_far_defect, path_alarm_forward;
	logic        path_far_defect, cell_delineation_lost, cell_slot_toggle;
	logic        rx_link_clk, rx_link_data, rx_link_first_group;
	logic        tx_link_clk, tx_link_first_group, test_data_out;
	logic        test_reset_n, test_clk, test_mode_sel, test_data_in;
	logic [7:0]  status_pins, alarm, slot_count;
	logic [2:0]  rx_bits;
	logic [1:0]  tx_bits;
	int          errors = 0;
	int          num_checks = 0;
	assign {signal_absent, frame_lost, pointer_invalid, line_alarm_forward,
		line_far_defect, path_alarm_forward, path_far_defect,
		cell_delineation_lost} = alarm;
	assign {rx_link_clk, rx_link_data, rx_link_first_group} = rx_bits;
	assign {tx_link_clk, tx_link_first_group} = tx_bits;
	status_output_pin_mux #(.WAN_VARIANT(1'b1)) DUT (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.signal_absent(signal_absent), .frame_lost(frame_lost),
		.pointer_invalid(pointer_invalid),
		.line_alarm_forward(line_alarm_forward),
		.line_far_defect(line_far_defect),
		.path_alarm_forward(path_alarm_forward),
		.path_far_defect(path_far_defect),
		.cell_delineation_lost(cell_delineation_lost),
		.rx_link_clk(rx_link_clk), .rx_link_data(rx_link_data),
		.rx_link_first_group(rx_link_first_group),
		.tx_link_clk(tx_link_clk),
		.tx_link_first_group(tx_link_first_group),
		.cell_slot_toggle(cell_slot_toggle),
		.test_reset_n(test_reset_n), .test_clk(test_clk),
		.test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
		.test_data_out(test_data_out), .status_pins(status_pins));
	board_monitor mon (.clk(clk), .rst_n(rst_n),
		.status_pins(status_pins), .slot_count(slot_count));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// whole run is about 280 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		summarize();
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		bus(1'b1, {i, 2'b00}, {24'h0, d}, r, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask
	task automatic rd(input logic [6:0] i, input logic [7:0] x, string n);
		logic [31:0] r;
		logic        e;
		bus(1'b0, {i, 2'b00}, 32'h0, r, e);
		chk(n, {24'h0, x}, r);
		chk("read error", 32'h0, {31'h0, e});
	endtask
	task automatic pins(input logic [7:0] x);
		repeat (3) @(posedge clk);
		chk("status pins", {24'h0, x}, {24'h0, status_pins});
	endtask
	// test clock kept well below clk/8 so the samplers see every edge
	task automatic tck(input logic m, input logic d);
		test_mode_sel <= m;
		test_data_in  <= d;
		repeat (8) @(posedge clk);
		test_clk <= 1'b1;
		repeat (8) @(posedge clk);
		test_clk <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset_values;
		rd(IDX_GLOBAL_CONFIG, RST_GLOBAL_CONFIG, "global_config");
		rd(IDX_PIN_VALUE, RST_PIN_VALUE, "pin_value_reg");
		rd(IDX_TX_SECTION_CFG, RST_TX_SECTION, "tx_section_config");
		rd(IDX_TX_LINE_CFG, RST_TX_LINE, "tx_line_config");
		rd(IDX_RX_LINE_CFG, RST_RX_LINE, "rx_line_config");
	endtask
	task t_value_mode;
		wr(IDX_PIN_VALUE, 8'hA5);
		pins(8'hA5);
		rd(IDX_PIN_VALUE_ALT, 8'hA5, "pin value alias");
		wr(IDX_PIN_VALUE_ALT, 8'h5A);
		pins(8'h5A);
		rd(IDX_PIN_STATE, 8'h5A, "pin state");
	endtask
	task t_alarm_mode;
		alarm <= 8'h96;
		wr(IDX_GLOBAL_CONFIG, 8'h04);
		pins(8'h96);
		alarm <= 8'h6D;
		pins(8'h6D);
	endtask
	task t_rx_link;
		rx_bits <= 3'b101;
		wr(IDX_RX_LINE_CFG, 8'h01);
		pins(8'hAD);
		rx_bits <= 3'b010;
		wr(IDX_RX_LINE_CFG, 8'h02);
		pins(8'h4D);
		wr(IDX_RX_LINE_CFG, 8'h00);
	endtask
	task t_tx_link;
		logic [7:0] c0;
		tx_bits <= 2'b10;
		wr(IDX_TX_LINE_CFG, 8'h10);
		pins(8'h71);
		c0 = slot_count;
		repeat (3)
		begin
			cell_slot_toggle <= ~cell_slot_toggle;
			repeat (10) @(posedge clk);
		end
		chk("slot pulses", 32'h3, {24'h0, slot_count - c0});
		tx_bits <= 2'b01;
		wr(IDX_TX_LINE_CFG, 8'h00);
		wr(IDX_TX_SECTION_CFG, 8'h40);
		pins(8'h69);
		wr(IDX_TX_SECTION_CFG, 8'h00);
	endtask
	task t_refused;
		logic [31:0] r;
		logic        e;
		bus(1'b0, 9'h00C, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		bus(1'b1, 9'h009, 32'h000000FF, r, e);
		chk("misaligned error", 32'h1, {31'h0, e});
		bus(1'b1, {IDX_PIN_STATE, 2'b00}, 32'h000000FF, r, e);
		chk("pin state write error", 32'h0, {31'h0, e});
		rd(IDX_PIN_STATE, 8'h6D, "pin state");
		rd(IDX_PIN_VALUE, 8'h5A, "pin value");
	endtask
	task t_tap;
		test_reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		test_reset_n <= 1'b1;
		tck(1'b0, 1'b0);
		tck(1'b1, 1'b0);
		tck(1'b0, 1'b0);
		repeat (4) tck(1'b0, 1'b1);
		chk("test data out", 32'h1, {31'h0, test_data_out});
		test_reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("test data out", 32'h0, {31'h0, test_data_out});
		test_reset_n <= 1'b1;
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{rst_n, psel, penable, pwrite, cell_slot_toggle} = 5'h00;
		{test_clk, test_mode_sel, test_data_in, test_reset_n} = 4'h1;
		{paddr, pwdata, alarm, rx_bits, tx_bits} = 54'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_values();
		t_value_mode();
		t_alarm_mode();
		t_rx_link();
		t_tx_link();
		t_refused();
		t_tap();
		summarize();
	end
endmodule
